// File: pkg/asfl_pkg.sv
/*
  Constants for the ALU status-flag logic: flag positions, operation codes,
  reset value of the flag register, datapath width.
  Assumes the decoder drives an operation code from asfl_op_e each cycle.
*/
`default_nettype none
package asfl_pkg;
  localparam int ASFL_DATA_W = 8;
  localparam int ASFL_NIBBLE_W = 4;
  // ===========================================
  // flag positions in the 3-bit flag register
  localparam int ASFL_CARRY_BIT = 0;
  localparam int ASFL_NIBBLE_BIT = 1;
  localparam int ASFL_ZERO_BIT = 2;
  localparam int ASFL_FLAGS_W = 3;
  localparam logic [2:0] ASFL_FLAGS_RST = 3'h0;
  // ===========================================
  // operations, one-hot
  typedef enum logic [7:0] {
    ASFL_OP_NONE = 8'h01,
    ASFL_OP_ADD_W_TO_FILE = 8'h02,
    ASFL_OP_ADD_LITERAL_TO_W = 8'h04,
    ASFL_OP_SUB_W_FROM_LITERAL = 8'h08,
    ASFL_OP_SUB_W_FROM_FILE = 8'h10,
    ASFL_OP_ROTATE_RIGHT = 8'h20,
    ASFL_OP_ROTATE_LEFT = 8'h40,
    ASFL_OP_LOGIC = 8'h80
  } asfl_op_e;
endpackage
`default_nettype wire

// File: verilog/asfl_adder.sv
/*
  Plain adder with carry-in that also reports the carry out of the low nibble.
  Assumes operands are already inverted by the caller for subtraction.
*/
`default_nettype none
module asfl_adder
  import asfl_pkg::*;
#(
  parameter int DATA_W = ASFL_DATA_W,
  parameter int NIB_W = ASFL_NIBBLE_W
) (
  input wire logic [DATA_W-1:0] opA,
  input wire logic [DATA_W-1:0] opB,
  input wire logic carryIn,
  output logic [DATA_W-1:0] sum,
  output logic nibbleCarry,
  output logic msbCarry
);
  logic [NIB_W:0] lowSum;
  logic [DATA_W:0] fullSum;

  if (NIB_W < 1 || NIB_W >= DATA_W) begin : gBadNibble
    $error("nibble width must lie inside the data width");
  end

  always_comb begin
    lowSum = {1'b0, opA[NIB_W-1:0]} + {1'b0, opB[NIB_W-1:0]} + {{NIB_W{1'b0}}, carryIn};
    fullSum = {1'b0, opA} + {1'b0, opB} + {{DATA_W{1'b0}}, carryIn};
    sum = fullSum[DATA_W-1:0];
    nibbleCarry = lowSum[NIB_W];
    msbCarry = fullSum[DATA_W];
  end
endmodule
`default_nettype wire

// File: verilog/asfl_flags.sv
/*
  Status-flag logic of the 8-bit ALU: result and carry, nibble carry and zero
  flags. Assumes the decoder presents operands and a one-hot operation code in
  the same cycle; result and flags appear one edge later.
*/
`default_nettype none
module asfl_flags
  import asfl_pkg::*;
#(
  parameter int DATA_W = ASFL_DATA_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire asfl_op_e opCode,
  input wire logic [DATA_W-1:0] wOperand,
  input wire logic [DATA_W-1:0] otherOperand,
  input wire logic [DATA_W-1:0] logicResult,
  output logic [DATA_W-1:0] result_reg,
  output logic [ASFL_FLAGS_W-1:0] flags_reg
);
  // ===========================================
  // parameter checks
  // rotates and checks below are written for the documented 8-bit width only
  if (DATA_W != ASFL_DATA_W) begin : gBadWidth
    $error("flag logic serves an 8-bit datapath only");
  end

  // ===========================================
  // operand steering
  logic isAdd;
  logic isSub;
  logic [DATA_W-1:0] addA;
  logic [DATA_W-1:0] addB;
  logic addCin;
  logic [DATA_W-1:0] sum;
  logic nibCarry;
  logic topCarry;

  // minuend is the file or literal operand, subtrahend is W
  always_comb begin
    isAdd = (opCode == ASFL_OP_ADD_W_TO_FILE) || (opCode == ASFL_OP_ADD_LITERAL_TO_W);
    isSub = (opCode == ASFL_OP_SUB_W_FROM_LITERAL) || (opCode == ASFL_OP_SUB_W_FROM_FILE);
    addA = otherOperand;
    addB = isSub ? ~wOperand : wOperand;
    addCin = isSub;
  end

  // one shared carry chain: borrow comes out inverted for free
  asfl_adder #(.DATA_W(DATA_W), .NIB_W(ASFL_NIBBLE_W)) uAdder (
    .opA(addA),
    .opB(addB),
    .carryIn(addCin),
    .sum(sum),
    .nibbleCarry(nibCarry),
    .msbCarry(topCarry)
  );

  // ===========================================
  // result and flags
  logic [DATA_W-1:0] result_next;
  logic [ASFL_FLAGS_W-1:0] flags_next;
  logic zeroUpdate;

  always_comb begin
    result_next = result_reg;
    flags_next = flags_reg;
    zeroUpdate = 1'b0;
    case (opCode)
      ASFL_OP_ADD_W_TO_FILE, ASFL_OP_ADD_LITERAL_TO_W,
      ASFL_OP_SUB_W_FROM_LITERAL, ASFL_OP_SUB_W_FROM_FILE: begin
        result_next = sum;
        flags_next[ASFL_NIBBLE_BIT] = nibCarry;
        flags_next[ASFL_CARRY_BIT] = topCarry;
        zeroUpdate = 1'b1;
      end
      ASFL_OP_ROTATE_RIGHT: begin
        result_next = {flags_reg[ASFL_CARRY_BIT], otherOperand[DATA_W-1:1]};
        flags_next[ASFL_CARRY_BIT] = otherOperand[0];
      end
      ASFL_OP_ROTATE_LEFT: begin
        result_next = {otherOperand[DATA_W-2:0], flags_reg[ASFL_CARRY_BIT]};
        flags_next[ASFL_CARRY_BIT] = otherOperand[DATA_W-1];
      end
      ASFL_OP_LOGIC: begin
        result_next = logicResult;
        zeroUpdate = 1'b1;
      end
      default: begin
        result_next = result_reg;
      end
    endcase
    // zero flag untouched by rotates, which leave it to the decoder's convention
    if (zeroUpdate) begin
      flags_next[ASFL_ZERO_BIT] = (result_next == '0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      result_reg <= '0;
    end else begin
      result_reg <= result_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flags_reg <= ASFL_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ===========================================
  // checks
  logic isArith;
  assign isArith = isAdd || isSub;

  sequence arith_issued;
    isArith;
  endsequence

  sequence add_issued;
    isAdd;
  endsequence

  sequence sub_issued;
    isSub;
  endsequence

  sequence rotate_issued;
    (opCode == ASFL_OP_ROTATE_RIGHT) || (opCode == ASFL_OP_ROTATE_LEFT);
  endsequence

  nibble_carry_a: assert property (@(posedge ref_clk) disable iff (srst)
    arith_issued |=> flags_reg[ASFL_NIBBLE_BIT] ==
      ($past(addA[3:0]) + $past(addB[3:0]) + 5'($past(addCin)) > 5'h0f))
    else $error("nibble flag wrong after add or subtract");

  msb_carry_a: assert property (@(posedge ref_clk) disable iff (srst)
    arith_issued |=> flags_reg[ASFL_CARRY_BIT] ==
      (9'($past(addA)) + 9'($past(addB)) + 9'($past(addCin)) > 9'h0ff))
    else $error("carry flag wrong after add or subtract");

  carry_position_a: assert property (@(posedge ref_clk) disable iff (srst)
    (opCode == ASFL_OP_ROTATE_RIGHT) |=> flags_reg[0] == $past(otherOperand[0]))
    else $error("carry flag not at bit 0");

  borrow_sense_a: assert property (@(posedge ref_clk) disable iff (srst)
    isSub |=> flags_reg[ASFL_CARRY_BIT] == ($past(otherOperand) >= $past(wOperand)))
    else $error("borrow polarity wrong");

  sub_result_a: assert property (@(posedge ref_clk) disable iff (srst)
    isSub |=> result_reg == 8'($past(otherOperand) - $past(wOperand)))
    else $error("subtraction result wrong");

  rotate_left_a: assert property (@(posedge ref_clk) disable iff (srst)
    (opCode == ASFL_OP_ROTATE_LEFT) |=> flags_reg[ASFL_CARRY_BIT] == $past(otherOperand[DATA_W-1])
      && result_reg[0] == $past(flags_reg[ASFL_CARRY_BIT]))
    else $error("left rotate through flag wrong");

  add_result_a: assert property (@(posedge ref_clk) disable iff (srst)
    isAdd |=> result_reg == 8'($past(otherOperand) + $past(wOperand)))
    else $error("addition result wrong");

  zero_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
    (isArith || opCode == ASFL_OP_LOGIC) |=> flags_reg[ASFL_ZERO_BIT] == (result_reg == '0))
    else $error("zero flag disagrees with result");

  idle_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    (opCode == ASFL_OP_NONE) |=> $stable(flags_reg) && $stable(result_reg))
    else $error("flags moved without an operation");

  // ===========================================
  // checks taken from the ports only
  // these do not look at the adder inputs, so a wrong operand inversion still shows
  add_nibble_a: assert property (@(posedge ref_clk) disable iff (srst)
    add_issued |=> flags_reg[ASFL_NIBBLE_BIT] ==
      (5'($past(otherOperand[ASFL_NIBBLE_W-1:0])) + 5'($past(wOperand[ASFL_NIBBLE_W-1:0])) > 5'h0f))
    else $error("nibble carry wrong after add");

  add_carry_a: assert property (@(posedge ref_clk) disable iff (srst)
    add_issued |=> flags_reg[ASFL_CARRY_BIT] ==
      (9'($past(otherOperand)) + 9'($past(wOperand)) > 9'h0ff))
    else $error("carry flag wrong after add");

  nibble_borrow_a: assert property (@(posedge ref_clk) disable iff (srst)
    sub_issued |=> flags_reg[ASFL_NIBBLE_BIT] ==
      ($past(otherOperand[ASFL_NIBBLE_W-1:0]) >= $past(wOperand[ASFL_NIBBLE_W-1:0])))
    else $error("nibble borrow polarity wrong");

  rotate_right_a: assert property (@(posedge ref_clk) disable iff (srst)
    (opCode == ASFL_OP_ROTATE_RIGHT) |=>
      result_reg == {$past(flags_reg[ASFL_CARRY_BIT]), $past(otherOperand[DATA_W-1:1])})
    else $error("right rotate through flag wrong");

  rotate_keeps_a: assert property (@(posedge ref_clk) disable iff (srst)
    rotate_issued |=> $stable(flags_reg[ASFL_ZERO_BIT]) && $stable(flags_reg[ASFL_NIBBLE_BIT]))
    else $error("rotate disturbed zero or nibble flag");

  logic_keeps_a: assert property (@(posedge ref_clk) disable iff (srst)
    (opCode == ASFL_OP_LOGIC) |=> $stable(flags_reg[ASFL_CARRY_BIT])
      && $stable(flags_reg[ASFL_NIBBLE_BIT]) && result_reg == $past(logicResult))
    else $error("logic result or carries wrong");

  // ===========================================
  // hold and reset checks
  // codes that are not one-hot fall to the default branch and must leave state alone
  bad_code_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !$onehot(opCode) |=> $stable(flags_reg) && $stable(result_reg))
    else $error("unknown operation code changed state");

  // no disable here: the reset itself is the antecedent
  reset_clear_a: assert property (@(posedge ref_clk)
    srst |=> (result_reg == '0) && (flags_reg == ASFL_FLAGS_RST))
    else $error("reset did not clear result and flags");
endmodule
`default_nettype wire

// File: verification/asfl_decoder_model.sv
/*
  Stand-in for the decoder and register file: presents one operation with its
  operands. Assumes issue is called just after a falling edge of ref_clk.
*/
`default_nettype none
module asfl_decoder_model
  import asfl_pkg::*;
(
  output var asfl_op_e opCode,
  output var logic [7:0] wOperand,
  output var logic [7:0] otherOperand,
  output var logic [7:0] logicResult
);
  timeunit 1ns;
  timeprecision 1ps;
  // ===========================================
  // idle: NONE holds the flags, operands set to a value that no test expects
  initial begin
    opCode = ASFL_OP_NONE;
    wOperand = 8'h5a;
    otherOperand = 8'ha5;
    logicResult = 8'h3c;
  end
  task automatic issue(input asfl_op_e op, input logic [7:0] w, input logic [7:0] o, input logic [7:0] l);
    opCode = op;
    wOperand = w;
    otherOperand = o;
    logicResult = l;
  endtask
endmodule
`default_nettype wire

// File: verification/alu_status_flag_logic_bench.sv
/*
  Self-checking bench for the status-flag logic: adds, subtracts, rotates,
  logic results and a mid-run reset. Assumes one clock at 100 MHz.
*/
`default_nettype none
module alu_status_flag_logic_bench
  import asfl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  asfl_op_e opCode;
  logic [7:0] wOp, oOp, lOp, res;
  logic [2:0] flg;
  logic eC = 1'b0, eN = 1'b0, eZ = 1'b0;
  logic [7:0] eR = 8'h00;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // ===========================================
  // clock, timeout and instances
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  asfl_decoder_model u_model (.opCode(opCode), .wOperand(wOp), .otherOperand(oOp), .logicResult(lOp));
  asfl_flags u_dut (.ref_clk(ref_clk), .srst(srst), .opCode(opCode), .wOperand(wOp), .otherOperand(oOp),
    .logicResult(lOp), .result_reg(res), .flags_reg(flg));
  // ===========================================
  // shared tasks
  task automatic checkOut();
    comparisons++;
    if ({res, flg} !== {eR, eZ, eN, eC}) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, {res, flg}, {eR, eZ, eN, eC});
    end
  endtask
  task automatic run(input asfl_op_e op, input logic [7:0] w, input logic [7:0] o, input logic [7:0] l);
    @(negedge ref_clk);
    u_model.issue(op, w, o, l);
    @(posedge ref_clk);
    #1;
    checkOut();
  endtask
  // ===========================================
  // scenarios; boundary pairs around the nibble and top-bit carries
  task automatic testAdd();
    logic [7:0] w[4] = '{8'h08, 8'h01, 8'h07, 8'h80};
    logic [7:0] o[4] = '{8'h08, 8'hff, 8'h08, 8'h80};
    for (int i = 0; i < 8; i++) begin
      {eC, eR} = o[i%4] + w[i%4];
      eN = (o[i%4][3:0] + w[i%4][3:0]) > 5'h0f;
      eZ = eR == 8'h00;
      run(i < 4 ? ASFL_OP_ADD_W_TO_FILE : ASFL_OP_ADD_LITERAL_TO_W, w[i%4], o[i%4], 8'h00);
    end
    $display("add test done");
  endtask
  task automatic testSub();
    logic [7:0] w[4] = '{8'h05, 8'h06, 8'h01, 8'h10};
    logic [7:0] o[4] = '{8'h05, 8'h05, 8'h10, 8'h01};
    for (int i = 0; i < 8; i++) begin
      eR = o[i%4] - w[i%4];
      eC = o[i%4] >= w[i%4];
      eN = o[i%4][3:0] >= w[i%4][3:0];
      eZ = eR == 8'h00;
      run(i < 4 ? ASFL_OP_SUB_W_FROM_FILE : ASFL_OP_SUB_W_FROM_LITERAL, w[i%4], o[i%4], 8'h00);
    end
    $display("subtract test done");
  endtask
  task automatic testRot();
    logic [7:0] o[3] = '{8'h81, 8'h80, 8'h01};
    for (int i = 0; i < 3; i++) begin
      eR = {eC, o[i][7:1]};
      eC = o[i][0];
      run(ASFL_OP_ROTATE_RIGHT, 8'h00, o[i], 8'h00);
      eR = {o[i][6:0], eC};
      eC = o[i][7];
      run(ASFL_OP_ROTATE_LEFT, 8'h00, o[i], 8'h00);
    end
    $display("rotate test done");
  endtask
  task automatic testLogic();
    eR = 8'h00;
    eZ = 1'b1;
    run(ASFL_OP_LOGIC, 8'hff, 8'hff, 8'h00);
    eR = 8'h40;
    eZ = 1'b0;
    run(ASFL_OP_LOGIC, 8'h00, 8'h00, 8'h40);
    run(ASFL_OP_NONE, 8'h00, 8'h00, 8'h00);
    // a code that is not one-hot must hold result and flags
    run(asfl_op_e'(8'h00), 8'h11, 8'h22, 8'h33);
    $display("logic test done");
  endtask
  task automatic testReset();
    @(negedge ref_clk);
    srst = 1'b1;
    {eR, eZ, eN, eC} = 11'h000;
    run(ASFL_OP_ADD_W_TO_FILE, 8'hff, 8'hff, 8'h00);
    @(negedge ref_clk);
    srst = 1'b0;
    u_model.issue(ASFL_OP_NONE, 8'h00, 8'h00, 8'h00);
    @(posedge ref_clk);
    #1;
    checkOut();
    $display("reset test done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    checkOut();
    @(negedge ref_clk);
    srst = 1'b0;
    testAdd();
    testSub();
    testRot();
    testLogic();
    testReset();
    testSub();
    report_and_stop();
  end
endmodule
`default_nettype wire
